// >>> verilog/prfh_top.sv
// Purpose: Routes incoming physical requests by source node and source bus.
// Assumes: Request words come from receive logic on the same clock.
// Notes: The host bus reset pin is synchronised before use.
`timescale 1ns/10ps
`include "prfh_params.svh"

module prfh_top (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic host_bus_reset,
    input wire logic [9:0] local_bus_id,
    input prfh_pkg::prfh_reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    input prfh_pkg::prfh_request_t rx_req,
    output prfh_pkg::prfh_decision_t decision,
    output logic accept_remote_bus_requests
);
    import prfh_pkg::*;

    // Returns one when the bus number names the controller's own bus.
    function automatic logic is_local_bus(
        input logic [9:0] bus,
        input logic [9:0] own_bus
    );
        logic local_hit;
        local_hit = (bus == own_bus) || (bus == `PRFH_LOCAL_BUS_ALIAS);
        return local_hit;
    endfunction : is_local_bus

    // Picks the route bit for a node; the top node has no bit at all.
    function automatic logic node_route_bit(
        input logic [31:0] low_filter,
        input logic [31:0] high_filter,
        input logic [5:0] node
    );
        logic hit;
        hit = 1'b0;
        if (node == `PRFH_NODE_NO_BIT) begin
            hit = 1'b0;
        end else if (node[5]) begin
            hit = high_filter[node[4:0]];
        end else begin
            hit = low_filter[node[4:0]];
        end
        return hit;
    endfunction : node_route_bit

    // Saturating increment used by the reject counter.
    function automatic logic [15:0] sat_inc(input logic [15:0] count);
        logic [15:0] result;
        result = count;
        if (count != `PRFH_COUNT_MAX) begin
            result = count + `PRFH_COUNT_ONE;
        end
        return result;
    endfunction : sat_inc

    // Returns one when the write strobe targets the given offset.
    function automatic logic write_hit(
        input prfh_reg_req_t req,
        input logic [11:0] offset
    );
        logic hit;
        hit = req.wr && (req.addr == offset);
        return hit;
    endfunction : write_hit

    // Packs the last decision into its status word.
    function automatic logic [31:0] pack_status(input prfh_decision_t status);
        logic [31:0] word;
        word = `PRFH_RDATA_RESET;
        word[10] = status.valid;
        word[9:8] = status.route;
        word[7] = status.ack;
        word[6] = status.remote;
        word[5:0] = status.src_node;
        return word;
    endfunction : pack_status

    // Read word for one offset.
    function automatic logic [31:0] read_word(
        input logic [11:0] addr,
        input logic [31:0] high_word,
        input logic [31:0] low_word,
        input logic [31:0] status_word,
        input logic [15:0] rejects
    );
        logic [31:0] word;
        word = `PRFH_RDATA_RESET;
        unique case (addr)
            `PRFH_OFS_HIGH_SET,
            `PRFH_OFS_HIGH_CLEAR: begin
                word = high_word;
            end
            `PRFH_OFS_LOW_SET,
            `PRFH_OFS_LOW_CLEAR: begin
                word = low_word;
            end
            `PRFH_OFS_LAST_DECISION: begin
                word = status_word;
            end
            `PRFH_OFS_REMOTE_REJECTS: begin
                word = {16'h0000, rejects};
            end
            // Unmapped offsets read as zero.
            default: begin
                word = `PRFH_RDATA_RESET;
            end
        endcase
        return word;
    endfunction : read_word

    // Host bus reset synchroniser.
    logic hbr_meta;
    logic hbr_sync;
    logic next_hbr_meta;
    logic next_hbr_sync;

    // Register decode strobes.
    logic high_set;
    logic high_clear;
    logic low_set;
    logic low_clear;
    logic rejects_clear;

    // Filter words.
    logic [31:0] high_filter;
    logic [31:0] low_filter;

    // Read path.
    logic [31:0] next_reg_rdata;

    // Decision path and status.
    prfh_decision_t next_decision;
    prfh_decision_t last_decision;
    prfh_decision_t next_last_decision;
    logic [15:0] remote_rejects;
    logic [15:0] next_remote_rejects;
    logic remote_rejected;
    logic source_local;

    // The first stage is read only by the second.
    always_comb begin
        next_hbr_meta = host_bus_reset;
        next_hbr_sync = hbr_meta;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hbr_meta <= 1'b0;
            hbr_sync <= 1'b0;
        end else if (clk_en) begin
            hbr_meta <= next_hbr_meta;
            hbr_sync <= next_hbr_sync;
        end
    end

    always_comb begin
        high_set = write_hit(reg_req, `PRFH_OFS_HIGH_SET);
        high_clear = write_hit(reg_req, `PRFH_OFS_HIGH_CLEAR);
        low_set = write_hit(reg_req, `PRFH_OFS_LOW_SET);
        low_clear = write_hit(reg_req, `PRFH_OFS_LOW_CLEAR);
        rejects_clear = write_hit(reg_req, `PRFH_OFS_REMOTE_REJECTS);
    end

    prfh_filter_cell u_high_filter (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .host_bus_reset(hbr_sync),
        .set_strobe(high_set),
        .clear_strobe(high_clear),
        .wdata(reg_req.wdata),
        .keep_mask(`PRFH_HIGH_KEEP_MASK),
        .value(high_filter)
    );

    prfh_filter_cell u_low_filter (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .host_bus_reset(hbr_sync),
        .set_strobe(low_set),
        .clear_strobe(low_clear),
        .wdata(reg_req.wdata),
        .keep_mask(`PRFH_LOW_KEEP_MASK),
        .value(low_filter)
    );

    // Bit 31 doubles as the remote-bus enable and survives host bus reset.
    assign accept_remote_bus_requests = high_filter[`PRFH_ALL_BUS_BIT];

    // Read data stand for exactly one cycle after the read strobe.
    always_comb begin
        next_reg_rdata = `PRFH_RDATA_RESET;
        if (reg_req.rd) begin
            next_reg_rdata = read_word(reg_req.addr, high_filter, low_filter,
                                       pack_status(last_decision), remote_rejects);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `PRFH_RDATA_RESET;
        end else if (clk_en) begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // The all-ones bus number is the local alias, so it counts as this bus.
    // Only local sources reach the per-node lookup.
    assign source_local = is_local_bus(rx_req.src_bus, local_bus_id);

    // Routing decision for one request word.
    always_comb begin
        next_decision = '0;
        next_decision.route = prfh_route_none;
        remote_rejected = 1'b0;
        if (rx_req.valid) begin
            next_decision.valid = 1'b1;
            next_decision.src_node = rx_req.src_node;
            if (!source_local) begin
                // Remote sources never reach the per-node lookup.
                next_decision.remote = 1'b1;
                if (accept_remote_bus_requests) begin
                    next_decision.ack = 1'b1;
                    if (rx_req.physical) begin
                        next_decision.route = prfh_route_phys;
                    end else begin
                        next_decision.route = prfh_route_async;
                    end
                end else begin
                    next_decision.ack = 1'b0;
                    next_decision.route = prfh_route_reject;
                    remote_rejected = 1'b1;
                end
            end else if (!rx_req.async_pass) begin
                next_decision.ack = 1'b0;
                next_decision.route = prfh_route_reject;
            end else if (!rx_req.physical) begin
                next_decision.ack = 1'b1;
                next_decision.route = prfh_route_async;
            end else if (node_route_bit(low_filter, high_filter, rx_req.src_node)) begin
                next_decision.ack = 1'b1;
                next_decision.route = prfh_route_phys;
            end else begin
                next_decision.ack = 1'b1;
                next_decision.route = prfh_route_async;
            end
        end
    end

    // Status: last decision and a count of refused remote packets.
    always_comb begin
        next_last_decision = last_decision;
        next_remote_rejects = remote_rejects;
        if (next_decision.valid) begin
            next_last_decision = next_decision;
        end
        if (rejects_clear) begin
            next_remote_rejects = `PRFH_COUNT_RESET;
        end
        // A refusal in the clearing cycle is still counted.
        if (remote_rejected) begin
            if (rejects_clear) begin
                next_remote_rejects = `PRFH_COUNT_ONE;
            end else begin
                next_remote_rejects = sat_inc(remote_rejects);
            end
        end
    end

    // Decision pulse, one cycle after the request.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            decision <= '0;
        end else if (clk_en) begin
            decision <= next_decision;
        end
    end

    // Last decision, held until the next request.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            last_decision <= '0;
        end else if (clk_en) begin
            last_decision <= next_last_decision;
        end
    end

    // Count of refused remote packets.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            remote_rejects <= `PRFH_COUNT_RESET;
        end else if (clk_en) begin
            remote_rejects <= next_remote_rejects;
        end
    end

endmodule : prfh_top

// >>> verilog/prfh_params.svh
// Purpose: Constants for the upper-node physical request filter block.
// Assumes: Included by the top and filter cell design files of the block by its bare name.
// Notes: Offsets are byte addresses on the 12-bit register port.
//
// What this block does
// - Filter is read, set-by-ones, clear-by-ones register.
// - All filter bits read zero after reset.
// - Same-bus sources: asynchronous filter first, then this filter.
// - Clear node bit diverts to async receive context.
// - Node lookup only for same-bus sources.
// - Remote packets unacknowledged unless bit 31 set.
// - Bit 31 set accepts all remote requests.
// - Host bus reset leaves bit 31 alone.
// - Bits 30..0 select nodes 62..32.
// - Set node bit routes to physical context.
// - Low register filters nodes 31..0 identically.
`ifndef PRFH_PARAMS_SVH
`define PRFH_PARAMS_SVH

`define PRFH_ADDR_W 12
`define PRFH_OFS_HIGH_SET 12'h110
`define PRFH_OFS_HIGH_CLEAR 12'h114
`define PRFH_OFS_LOW_SET 12'h118
`define PRFH_OFS_LOW_CLEAR 12'h11C
`define PRFH_OFS_LAST_DECISION 12'h130
`define PRFH_OFS_REMOTE_REJECTS 12'h134

`define PRFH_FILTER_RESET 32'h0000_0000
`define PRFH_RDATA_RESET 32'h0000_0000
`define PRFH_HIGH_KEEP_MASK 32'h8000_0000
`define PRFH_LOW_KEEP_MASK 32'h0000_0000
`define PRFH_ALL_BUS_BIT 31

`define PRFH_NODE_NO_BIT 6'h3F
`define PRFH_LOCAL_BUS_ALIAS 10'h3FF
`define PRFH_COUNT_RESET 16'h0000
`define PRFH_COUNT_MAX 16'hFFFF
`define PRFH_COUNT_ONE 16'h0001

`endif

// >>> verilog/prfh_pkg.sv
// Purpose: Types shared by the physical request filter block.
// Assumes: Constants come from prfh_params.svh.
// Notes: Source id is split into a 10-bit bus number and a 6-bit node.
package prfh_pkg;

    typedef enum logic [1:0] {
        prfh_route_none = 2'b00,
        prfh_route_phys = 2'b01,
        prfh_route_async = 2'b10,
        prfh_route_reject = 2'b11
    } prfh_route_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } prfh_reg_req_t;

    typedef struct packed {
        logic valid;
        logic physical;
        logic async_pass;
        logic [9:0] src_bus;
        logic [5:0] src_node;
    } prfh_request_t;

    typedef struct packed {
        logic valid;
        prfh_route_t route;
        logic ack;
        logic remote;
        logic [5:0] src_node;
    } prfh_decision_t;

endpackage : prfh_pkg

// >>> verilog/prfh_filter_cell.sv
// Purpose: One 32-bit read/set/clear filter word.
// Assumes: Set and clear strobes never arrive together.
// Notes: Bits in keep_mask survive the host bus reset.
`timescale 1ns/10ps
`include "prfh_params.svh"

module prfh_filter_cell (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic host_bus_reset,
    input wire logic set_strobe,
    input wire logic clear_strobe,
    input wire logic [31:0] wdata,
    input wire logic [31:0] keep_mask,
    output logic [31:0] value
);
    import prfh_pkg::*;

    logic [31:0] next_value;

    always_comb begin
        next_value = value;
        if (host_bus_reset) begin
            next_value = value & keep_mask;
        end else begin
            if (set_strobe) begin
                next_value = next_value | wdata;
            end
            if (clear_strobe) begin
                next_value = next_value & ~wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            value <= `PRFH_FILTER_RESET;
        end else if (clk_en) begin
            value <= next_value;
        end
    end

endmodule : prfh_filter_cell

// >>> test/prfh_monitor.sv
// Purpose: Port checker for the upper-node physical request filter.
// Assumes: Sees only the ports of prfh_top.
// Notes: Bound to every prfh_top instance.
`timescale 1ns/10ps

module prfh_monitor (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic host_bus_reset,
    input wire logic [9:0] local_bus_id,
    input prfh_pkg::prfh_reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    input prfh_pkg::prfh_request_t rx_req,
    input prfh_pkg::prfh_decision_t decision,
    input wire logic accept_remote_bus_requests
);
    import prfh_pkg::*;
    logic take;
    logic far;
    logic near_ok;
    assign take = clk_en && rx_req.valid;
    assign far = rx_req.src_bus != local_bus_id && rx_req.src_bus != 10'h03FF;
    assign near_ok = take && !far && rx_req.async_pass;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_RDATA_IDLE: assert property (
        clk_en && !reg_req.rd |=> reg_rdata == 32'h0000_0000) else $error("stray read data");
    AST_READ_BIT31: assert property (
        clk_en && reg_req.rd && reg_req.addr == 12'h0110 |=>
        reg_rdata[31] == accept_remote_bus_requests) else $error("bit 31 read differs");
    AST_KEEP_REMOTE: assert property (
        !reg_req.wr |=> $stable(accept_remote_bus_requests)) else $error("remote enable moved");
    AST_DECISION: assert property (
        take |=> decision.valid && decision.src_node == $past(rx_req.src_node)
        && decision.remote == $past(far)) else $error("decision missing");
    AST_NO_DECISION: assert property (
        clk_en && !rx_req.valid |=> !decision.valid) else $error("spurious decision");
    AST_REMOTE_REJECT: assert property (
        take && far && !accept_remote_bus_requests |=>
        !decision.ack && decision.route == prfh_route_reject) else $error("remote acked");
    AST_REMOTE_ACCEPT: assert property (
        take && far && accept_remote_bus_requests |=> decision.ack
        && decision.route != prfh_route_reject) else $error("remote refused");
    AST_ASYNC_FAIL: assert property (
        take && !far && !rx_req.async_pass |=> !decision.ack
        && decision.route == prfh_route_reject) else $error("async filter ignored");
    AST_NODE63: assert property (
        near_ok && rx_req.physical && rx_req.src_node == 6'h3F |=>
        decision.route == prfh_route_async) else $error("node 63 matched");
endmodule : prfh_monitor

bind prfh_top prfh_monitor u_mon (
    .clock(clock), .nrst(nrst), .clk_en(clk_en), .host_bus_reset(host_bus_reset),
    .local_bus_id(local_bus_id), .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_req(rx_req),
    .decision(decision), .accept_remote_bus_requests(accept_remote_bus_requests));

// >>> test/prfh_rx_model.sv
// Purpose: Receive path model that hands request words to the filter.
// Assumes: One request per call, valid high for one cycle.
// Notes: Idle fields are inverted so stale values are never reused.
`timescale 1ns/10ps

module prfh_rx_model (
    input wire logic clock,
    output prfh_pkg::prfh_request_t rx_req
);
    import prfh_pkg::*;
    initial rx_req = '0;
    task automatic send(input logic [9:0] b, input logic [5:0] n, input logic p, input logic a);
        @(posedge clock);
        rx_req <= '{1'b1, p, a, b, n};
        @(posedge clock);
        rx_req <= '{1'b0, ~p, ~a, ~b, ~n};
    endtask : send
endmodule : prfh_rx_model

// >>> test/prfh_top_tb.sv
// Purpose: Self-checking bench for the upper-node physical request filter.
// Assumes: Local bus number is 001h, clock enable held high except in the freeze test.
// Notes: Each scenario checks its own results.
`timescale 1ns/10ps

module prfh_top_tb;
    import prfh_pkg::*;
    logic clock;
    logic nrst;
    logic host_bus_reset;
    logic clk_en;
    prfh_reg_req_t reg_req;
    prfh_request_t rx_req;
    logic [31:0] reg_rdata;
    prfh_decision_t decision;
    logic accept_remote_bus_requests;
    int bad_count;
    int check_count;

    prfh_top u_dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .host_bus_reset(host_bus_reset),
        .local_bus_id(10'h0001), .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_req(rx_req),
        .decision(decision), .accept_remote_bus_requests(accept_remote_bus_requests));
    prfh_rx_model u_src (.clock(clock), .rx_req(rx_req));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clock);
        reg_req <= '0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clock);
        reg_req <= '0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic req(input logic [9:0] b, input logic [5:0] n, input logic a,
        input prfh_route_t r, input logic k);
        u_src.send(b, n, 1'b1, a);
        #1;
        chk({28'h000_0000, decision.valid, decision.ack, decision.route}, {28'h000_0000, 1'b1, k, r});
    endtask : req

    task automatic t_reset;
        chk({31'h0000_0000, accept_remote_bus_requests}, 32'h0000_0000);
        rd(12'h0110, 32'h0000_0000);
        rd(12'h011C, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_local;
        wr(12'h0110, 32'h4000_0001);
        rd(12'h0114, 32'h4000_0001);
        req(10'h0001, 6'h3E, 1'b1, prfh_route_phys, 1'b1);
        req(10'h0001, 6'h20, 1'b1, prfh_route_phys, 1'b1);
        req(10'h0001, 6'h21, 1'b1, prfh_route_async, 1'b1);
        req(10'h0001, 6'h3F, 1'b1, prfh_route_async, 1'b1);
        req(10'h0001, 6'h3E, 1'b0, prfh_route_reject, 1'b0);
        wr(12'h0114, 32'h0000_0001);
        rd(12'h0110, 32'h4000_0000);
        req(10'h0001, 6'h20, 1'b1, prfh_route_async, 1'b1);
        req(10'h0001, 6'h05, 1'b1, prfh_route_async, 1'b1);
        wr(12'h0118, 32'h0000_0020);
        req(10'h0001, 6'h05, 1'b1, prfh_route_phys, 1'b1);
        $display("test local done");
    endtask : t_local

    task automatic t_remote;
        req(10'h0002, 6'h3E, 1'b1, prfh_route_reject, 1'b0);
        rd(12'h0134, 32'h0000_0001);
        wr(12'h0134, 32'h0000_0000);
        rd(12'h0134, 32'h0000_0000);
        wr(12'h0110, 32'h8000_0000);
        req(10'h0002, 6'h21, 1'b1, prfh_route_phys, 1'b1);
        req(10'h03FF, 6'h21, 1'b1, prfh_route_async, 1'b1);
        rd(12'h0130, 32'h0000_06A1);
        $display("test remote done");
    endtask : t_remote

    task automatic t_freeze;
        @(posedge clock);
        clk_en <= 1'b0;
        wr(12'h0114, 32'hC000_0000);
        clk_en <= 1'b1;
        rd(12'h0110, 32'hC000_0000);
        $display("test freeze done");
    endtask : t_freeze

    task automatic t_host;
        @(posedge clock);
        host_bus_reset <= 1'b1;
        repeat (6) @(posedge clock);
        host_bus_reset <= 1'b0;
        repeat (4) @(posedge clock);
        rd(12'h0110, 32'h8000_0000);
        rd(12'h0118, 32'h0000_0000);
        chk({31'h0000_0000, accept_remote_bus_requests}, 32'h0000_0001);
        $display("test host reset done");
    endtask : t_host

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        finish_test();
    end

    initial begin
        nrst = 1'b0;
        host_bus_reset = 1'b0;
        clk_en = 1'b1;
        reg_req = '0;
        bad_count = 0;
        check_count = 0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_local();
        t_remote();
        t_freeze();
        t_host();
        finish_test();
    end
endmodule : prfh_top_tb
